// ---- pkg/tpc_pkg.sv ----
// Purpose: constants for the power-path control and line status register pair
// Assumes: 8-bit register access port driven by the serial host engine on core_clk
// Notes:   all offsets, power control fields and reset values are named here
//
// Function
// R1: power bit 6 set turns bus level meter off; readout then all zero; resets 1
// R2: power bit 5 set hides high/low voltage alarm reporting; resets 1
// R3: power bit 4 clear blocks any automatic voltage-based bus discharge; resets 0
// R4: power bit 3 drives the bleed discharge path on or off; resets 0
// R5: power bit 2 starts forced discharge; hardware clears it once level is reached
// R6: power bit 1 selects cable power level: 0 at least 1W, 1 advertised amount
// R7: power bit 0 sources cable power onto the pin picked by flip select
// R8: lines sampled periodically and on every status read unless signalling is busy
// R9: status bit 5 is one while searching; its fall means a connection was found
// R10: status bit 4 shows termination presented: 0 pull-up, 1 pull-down
// R11: source view pin state: 00 open, 01 Ra seen, 10 Rd seen, 11 reserved
// R12: sink view pin state: 00 open, rising codes up to 11 for 3.0 A source
// R13: pin state reads 00 while that pin's role is Ra or open
// R14: line two state reads 00 while searching or cable power sits on line two
// R15: line one state reads 00 while searching or cable power sits on line one
// R16: flip select 1 puts cable power on line one, 0 on line two
// R17: role codes: 00 Ra, 01 Rp, 10 Rd, 11 open
// R18: reserved bits read zero and ignore writes
package tpc_pkg;
  localparam logic [7:0] PWR_CTRL_OFS  = 8'h1c;
  localparam logic [7:0] CC_STAT_OFS   = 8'h1d;
  localparam logic [6:0] PWR_CTRL_RST  = 7'h60;
  localparam logic [5:0] CC_STAT_RST   = 6'h00;
  localparam logic [6:0] PWR_WR_MASK   = 7'h7f;
  localparam int         METER_OFF_BIT = 6;
  localparam int         ALARM_OFF_BIT = 5;
  localparam int         AUTO_DRN_BIT  = 4;
  localparam int         BLEED_BIT     = 3;
  localparam int         FORCE_DRN_BIT = 2;
  localparam int         CABLE_LVL_BIT = 1;
  localparam int         CABLE_ON_BIT  = 0;
  localparam int         LEVEL_W       = 10;
  localparam int         POLL_W        = 16;
  localparam logic [1:0] ROLE_RA       = 2'h0;
  localparam logic [1:0] ROLE_RP       = 2'h1;
  localparam logic [1:0] ROLE_RD       = 2'h2;
  localparam logic [1:0] ROLE_OPEN     = 2'h3;
  localparam logic [1:0] LINE_OPEN     = 2'h0;
endpackage

// ---- pkg/tpc_sample_if.sv ----
// Purpose: carries sample requests and sampled line levels between register and sampler
// Assumes: single core_clk domain
// Notes:   regs modport requests, sampler modport answers
`timescale 1ns/1ps
`default_nettype none
interface tpc_sample_if;
  logic                      read_req;
  logic                      pd_busy;
  logic [tpc_pkg::POLL_W-1:0] poll_interval;
  logic [1:0]                line_one_level;
  logic [1:0]                line_two_level;

  modport regs (output read_req, output pd_busy, output poll_interval,
                input line_one_level, input line_two_level);
  modport sampler (input read_req, input pd_busy, input poll_interval,
                   output line_one_level, output line_two_level);
endinterface
`default_nettype wire

// ---- hw/tpc_line_sampler.sv ----
// Purpose: periodic and on-demand sampling of the two line comparator codes
// Assumes: comparator codes arrive asynchronously from the analogue front end
// Notes:   a sample is taken every poll_interval+1 cycles or on a read request while pd_busy is low
`timescale 1ns/1ps
`default_nettype none
module tpc_line_sampler (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [1:0] line_one_raw,
  input  wire logic [1:0] line_two_raw,
  tpc_sample_if.sampler   smp
);
  typedef struct packed {
    logic [tpc_pkg::POLL_W-1:0] count;
    logic [1:0]                 one_s1;
    logic [1:0]                 one_s2;
    logic [1:0]                 two_s1;
    logic [1:0]                 two_s2;
    logic [1:0]                 one_smp;
    logic [1:0]                 two_smp;
  } tpc_smp_state_t;

  tpc_smp_state_t st_ff;
  tpc_smp_state_t nxt_st;
  logic           take;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.one_s1 = line_one_raw;
    nxt_st.one_s2 = st_ff.one_s1;
    nxt_st.two_s1 = line_two_raw;
    nxt_st.two_s2 = st_ff.two_s1;
    take = (st_ff.count >= smp.poll_interval) || (smp.read_req && !smp.pd_busy); // R8
    if (take) begin
      nxt_st.count   = '0;
      nxt_st.one_smp = st_ff.one_s2;
      nxt_st.two_smp = st_ff.two_s2;
    end else begin
      nxt_st.count = st_ff.count + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign smp.line_one_level = st_ff.one_smp;
  assign smp.line_two_level = st_ff.two_smp;
endmodule
`default_nettype wire

// ---- hw/tpc_power_cc_regs.sv ----
// Purpose: power-path control register and line status register
// Assumes: register port comes from the serial host engine on core_clk
// Notes:   read data appears one cycle after the read strobe and holds
`timescale 1ns/1ps
`default_nettype none
module tpc_power_cc_regs (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        flip_select,
  input  wire logic [1:0]                  line_one_role,
  input  wire logic [1:0]                  line_two_role,
  input  wire logic [tpc_pkg::POLL_W-1:0]  line_poll_interval,
  input  wire logic                        pd_busy,
  input  wire logic                        attach_search_active,
  input  wire logic                        connect_result,
  input  wire logic [1:0]                  line_one_raw,
  input  wire logic [1:0]                  line_two_raw,
  input  wire logic [tpc_pkg::LEVEL_W-1:0] bus_level_code,
  input  wire logic                        upper_alarm_hit,
  input  wire logic                        lower_alarm_hit,
  input  wire logic                        bus_low_drain_req,
  input  wire logic                        drain_level_reached,
  output logic [tpc_pkg::LEVEL_W-1:0]      bus_level_read,
  output logic                             upper_alarm_rpt,
  output logic                             lower_alarm_rpt,
  output logic                             auto_drain_on,
  output logic                             bleed_drain_on,
  output logic                             force_drain_on,
  output logic                             cable_power_level,
  output logic                             cable_power_line_one,
  output logic                             cable_power_line_two
);
  typedef struct packed {
    logic [6:0]                  pwr;
    logic [5:0]                  stat;
    logic [7:0]                  rdata;
    logic                        done_s1;
    logic                        done_s2;
    logic [tpc_pkg::LEVEL_W-1:0] level;
    logic                        hi_rpt;
    logic                        lo_rpt;
    logic                        auto_on;
    logic                        bleed_on;
    logic                        pwr_one;
    logic                        pwr_two;
  } tpc_reg_state_t;

  tpc_reg_state_t st_ff;
  tpc_reg_state_t nxt_st;
  tpc_sample_if   smp_if ();

  // ---------------------------------------------------------------
  // pin state masking
  // ---------------------------------------------------------------
  // sampled code passes only for an Rp or Rd role and an unblocked pin
  function automatic logic [1:0] line_state(input logic [1:0] role,
                                            input logic       blocked,
                                            input logic [1:0] level);
    if (blocked || role == tpc_pkg::ROLE_RA || role == tpc_pkg::ROLE_OPEN) begin // R13 R17
      line_state = tpc_pkg::LINE_OPEN;
    end else begin
      line_state = level; // R11 R12
    end
  endfunction

  tpc_line_sampler u_sampler (
    .core_clk     (core_clk),
    .reset        (reset),
    .line_one_raw (line_one_raw),
    .line_two_raw (line_two_raw),
    .smp          (smp_if.sampler)
  );

  assign smp_if.read_req      = reg_rd && (reg_addr == tpc_pkg::CC_STAT_OFS); // R8
  assign smp_if.pd_busy       = pd_busy;
  assign smp_if.poll_interval = line_poll_interval;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       vconn_on;
    logic [1:0] one_st;
    logic [1:0] two_st;
    vconn_on = st_ff.pwr[tpc_pkg::CABLE_ON_BIT];
    one_st   = tpc_pkg::LINE_OPEN;
    two_st   = tpc_pkg::LINE_OPEN;
    nxt_st = st_ff;
    nxt_st.done_s1 = drain_level_reached;
    nxt_st.done_s2 = st_ff.done_s1;

    // hardware clears forced discharge; a write in the same cycle wins
    if (st_ff.done_s2) begin
      nxt_st.pwr[tpc_pkg::FORCE_DRN_BIT] = 1'b0; // R5
    end
    if (reg_wr && reg_addr == tpc_pkg::PWR_CTRL_OFS) begin
      nxt_st.pwr = reg_wdata[6:0] & tpc_pkg::PWR_WR_MASK; // R18
    end

    // cable power pin from flip select
    nxt_st.pwr_one = vconn_on && flip_select;  // R7 R16
    nxt_st.pwr_two = vconn_on && !flip_select; // R7 R16

    one_st = line_state(line_one_role,
                        attach_search_active || (vconn_on && flip_select),   // R15
                        smp_if.line_one_level);
    two_st = line_state(line_two_role,
                        attach_search_active || (vconn_on && !flip_select),  // R14
                        smp_if.line_two_level);
    nxt_st.stat = {attach_search_active, connect_result, two_st, one_st}; // R9 R10

    if (st_ff.pwr[tpc_pkg::METER_OFF_BIT]) begin
      nxt_st.level = '0; // R1
    end else begin
      nxt_st.level = bus_level_code;
    end
    nxt_st.hi_rpt   = upper_alarm_hit && !st_ff.pwr[tpc_pkg::ALARM_OFF_BIT]; // R2
    nxt_st.lo_rpt   = lower_alarm_hit && !st_ff.pwr[tpc_pkg::ALARM_OFF_BIT]; // R2
    nxt_st.auto_on  = bus_low_drain_req && st_ff.pwr[tpc_pkg::AUTO_DRN_BIT]; // R3
    nxt_st.bleed_on = st_ff.pwr[tpc_pkg::BLEED_BIT];                         // R4

    if (reg_rd) begin
      case (reg_addr)
        tpc_pkg::PWR_CTRL_OFS: begin
          nxt_st.rdata = {1'b0, st_ff.pwr}; // R18
        end
        tpc_pkg::CC_STAT_OFS: begin
          nxt_st.rdata = {2'b00, st_ff.stat}; // R18
        end
        default: begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff      <= '0;
      st_ff.pwr  <= tpc_pkg::PWR_CTRL_RST;
      st_ff.stat <= tpc_pkg::CC_STAT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata            = st_ff.rdata;
  assign bus_level_read       = st_ff.level;
  assign upper_alarm_rpt      = st_ff.hi_rpt;
  assign lower_alarm_rpt      = st_ff.lo_rpt;
  assign auto_drain_on        = st_ff.auto_on;
  assign bleed_drain_on       = st_ff.bleed_on;
  assign force_drain_on       = st_ff.pwr[tpc_pkg::FORCE_DRN_BIT];  // R5
  assign cable_power_level    = st_ff.pwr[tpc_pkg::CABLE_LVL_BIT];  // R6
  assign cable_power_line_one = st_ff.pwr_one;
  assign cable_power_line_two = st_ff.pwr_two;
endmodule
`default_nettype wire

// ---- dv/tpc_regs_sva.sv ----
// Purpose: port assertions for the power control and line status registers
// Assumes: single core_clk domain, synchronous active high reset
// Notes:   power bits are shadowed from host writes
`timescale 1ns/1ps
`default_nettype none
module tpc_regs_sva (
  input wire logic                        core_clk,
  input wire logic                        reset,
  input wire logic [7:0]                  reg_addr,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_wdata,
  input wire logic [7:0]                  reg_rdata,
  input wire logic                        flip_select,
  input wire logic                        attach_search_active,
  input wire logic [tpc_pkg::LEVEL_W-1:0] bus_level_code,
  input wire logic                        upper_alarm_hit,
  input wire logic                        lower_alarm_hit,
  input wire logic                        bus_low_drain_req,
  input wire logic                        drain_level_reached,
  input wire logic [tpc_pkg::LEVEL_W-1:0] bus_level_read,
  input wire logic                        upper_alarm_rpt,
  input wire logic                        lower_alarm_rpt,
  input wire logic                        auto_drain_on,
  input wire logic                        bleed_drain_on,
  input wire logic                        force_drain_on,
  input wire logic                        cable_power_level,
  input wire logic                        cable_power_line_one,
  input wire logic                        cable_power_line_two
);
  logic [6:0] sh_ff;
  logic       pwr_wr;
  assign pwr_wr = reg_wr && reg_addr == tpc_pkg::PWR_CTRL_OFS;
  always_ff @(posedge core_clk) begin
    if (reset) sh_ff <= tpc_pkg::PWR_CTRL_RST;
    else if (pwr_wr) sh_ff <= reg_wdata[6:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence drain_seen;
    $rose(drain_level_reached) ##0 !pwr_wr [*4];
  endsequence
  sequence search_read;
    attach_search_active [*3] ##0 (reg_rd && reg_addr == tpc_pkg::CC_STAT_OFS);
  endsequence
  chk_meter_zero: assert property (bus_level_read == ($past(sh_ff[6]) ? '0 : $past(bus_level_code)))
    else $error("level readout wrong");
  chk_alarm_hide: assert property (upper_alarm_rpt == ($past(upper_alarm_hit) && !$past(sh_ff[5])))
    else $error("alarm report wrong");
  chk_auto_drain: assert property (auto_drain_on == ($past(bus_low_drain_req) && $past(sh_ff[4])))
    else $error("auto discharge wrong");
  chk_alarm_low: assert property (lower_alarm_rpt == ($past(lower_alarm_hit) && !$past(sh_ff[5])))
    else $error("low alarm report wrong");
  chk_bleed_path: assert property (bleed_drain_on == $past(sh_ff[3]))
    else $error("bleed discharge wrong");
  chk_cable_level: assert property (cable_power_level == sh_ff[1])
    else $error("cable power level wrong");
  chk_cable_two: assert property (cable_power_line_two == ($past(sh_ff[0]) && !$past(flip_select)))
    else $error("cable power line two wrong");
  chk_force_set: assert property (pwr_wr |=> force_drain_on == $past(reg_wdata[2]))
    else $error("forced discharge not set");
  chk_force_clear: assert property (drain_seen |=> !force_drain_on)
    else $error("forced discharge not cleared");
  chk_cable_line: assert property (cable_power_line_one == ($past(sh_ff[0]) && $past(flip_select)))
    else $error("cable power line wrong");
  chk_search_read: assert property (search_read |=> reg_rdata[7:5] == 3'h1 && reg_rdata[3:0] == 4'h0)
    else $error("search status wrong");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > tpc_pkg::CC_STAT_OFS |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind tpc_power_cc_regs tpc_regs_sva i_tpc_regs_sva (.*);
`default_nettype wire

// ---- dv/tpc_host_model.sv ----
// Purpose: port manager model issuing single byte register accesses
// Assumes: one-cycle strobes launched at the falling edge
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module tpc_host_model (
  input  wire logic  core_clk,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the power control and line status registers
// Assumes: inputs driven at the falling edge, read data checked one cycle on
// Notes:   expected read values queued by the driver, popped by the monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                        core_clk, reset, reg_wr, reg_rd, pend, flip_select, pd_busy;
  logic                        attach_search_active, connect_result, drain_level_reached;
  logic                        upper_alarm_hit, lower_alarm_hit, bus_low_drain_req;
  logic                        upper_alarm_rpt, lower_alarm_rpt, auto_drain_on, bleed_drain_on;
  logic                        force_drain_on, cable_power_level;
  logic                        cable_power_line_one, cable_power_line_two;
  logic [7:0]                  reg_addr, reg_wdata, reg_rdata;
  logic [1:0]                  line_one_role, line_two_role, line_one_raw, line_two_raw;
  logic [tpc_pkg::POLL_W-1:0]  line_poll_interval;
  logic [tpc_pkg::LEVEL_W-1:0] bus_level_code, bus_level_read;
  logic [7:0]                  exp_q[$];
  int                          bad_count, compares, cyc;
  tpc_power_cc_regs i_tpc_power_cc_regs (.*);
  tpc_host_model i_tpc_host_model (.*);
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  task automatic conclude();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: read %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_tpc_host_model.rd(a);
  endtask
  function automatic logic [1:0] st(input logic [1:0] role, input logic [1:0] raw);
    return (role == tpc_pkg::ROLE_RA || role == tpc_pkg::ROLE_OPEN) ? tpc_pkg::LINE_OPEN : raw;
  endfunction
  always @(posedge core_clk) pend <= reg_rd;
  always @(negedge core_clk) if (pend) check(reg_rdata, exp_q.pop_front());
  always @(negedge core_clk) begin
    bus_level_code <= tpc_pkg::LEVEL_W'($urandom);
    {upper_alarm_hit, lower_alarm_hit, bus_low_drain_req} <= 3'($urandom);
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(83));
    {reset, flip_select, pd_busy, attach_search_active, connect_result} = 5'h11;
    drain_level_reached = 1'b0;
    {line_one_role, line_two_role, line_one_raw, line_two_raw} = 8'h00;
    line_poll_interval = '0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    rdx(8'h1c, 8'h60);
    rdx(8'h1d, 8'h10);
    rdx(8'h3f, 8'h00);
    i_tpc_host_model.wr(8'h1c, 8'hfb);
    rdx(8'h1c, 8'h7b);
    i_tpc_host_model.wr(8'h1d, 8'hff);
    rdx(8'h1d, 8'h10);
    i_tpc_host_model.wr(8'h1c, 8'h18);
    repeat (20) @(negedge core_clk);
    i_tpc_host_model.wr(8'h1c, 8'h04);
    rdx(8'h1c, 8'h04);
    drain_level_reached = 1'b1;
    repeat (6) @(negedge core_clk);
    rdx(8'h1c, 8'h00);
    drain_level_reached = 1'b0;
    for (int r = 0; r < 4; r++) begin
      {line_one_role, line_two_role} = {2'(r), 2'(3 - r)};
      {line_one_raw, line_two_raw, connect_result} = 5'($urandom);
      repeat (5) @(negedge core_clk);
      rdx(8'h1d, {3'h0, connect_result, st(line_two_role, line_two_raw),
                  st(line_one_role, line_one_raw)});
    end
    attach_search_active = 1'b1;
    repeat (3) @(negedge core_clk);
    rdx(8'h1d, {3'h1, connect_result, 4'h0});
    {attach_search_active, line_one_role, line_two_role} = {1'b0, tpc_pkg::ROLE_RP, tpc_pkg::ROLE_RP};
    {line_one_raw, line_two_raw} = 4'h9;
    i_tpc_host_model.wr(8'h1c, 8'h01);
    for (int f = 0; f < 2; f++) begin
      flip_select = 1'(f);
      repeat (5) @(negedge core_clk);
      rdx(8'h1d, {3'h0, connect_result, flip_select ? 2'h1 : 2'h0, flip_select ? 2'h0 : 2'h2});
    end
    i_tpc_host_model.wr(8'h1c, 8'h00);
    line_poll_interval = 16'hffff;
    repeat (5) @(negedge core_clk);
    {line_one_raw, line_two_raw, pd_busy} = 5'h03;
    repeat (4) @(negedge core_clk);
    rdx(8'h1d, {3'h0, connect_result, 4'h6});
    repeat (3) @(negedge core_clk);
    rdx(8'h1d, {3'h0, connect_result, 4'h6});
    pd_busy = 1'b0;
    rdx(8'h1d, {3'h0, connect_result, 4'h6});
    repeat (3) @(negedge core_clk);
    rdx(8'h1d, {3'h0, connect_result, 4'h4});
    repeat (3) @(negedge core_clk);
    conclude();
  end
endmodule
`default_nettype wire
